// ==== dv/hci_info_status_test.sv ====
// self-checking bench for the informational and status command block
`timescale 1ns/100ps
`default_nettype none
module hci_info_status_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_opcode = 16'h0000;
  logic [15:0] cmd_handle = 16'h0000;
  logic evt_mask = 1'b0;
  logic cmd_ready;
  logic evt_valid;
  logic [7:0] evt_byte;
  logic evt_last;
  logic evt_ready;
  logic [7:0] conn_open = 8'h00;
  logic [7:0] conn_close = 8'h00;
  logic [11:0] conn_new_hdl = 12'h000;
  logic [7:0] flush_evt = 8'h00;
  logic [7:0] ack_evt = 8'h00;
  logic [hci_pkg::NUM_CONN-1:0][7:0] rssi_level = '0;
  logic [7:0] country_sel = 8'h00;
  logic [47:0] dev_addr = 48'h0;
  int err_count = 0;
  int num_checks = 0;
  int seed = 32'hf087b75c;
  int cnt[8];
  bit live[8];
  logic [15:0] hdl_of[8];
  logic [7:0] exp_q[$];

  hci_info_status DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_handle(cmd_handle), .evt_mask(evt_mask), .cmd_ready(cmd_ready), .evt_valid(evt_valid),
    .evt_byte(evt_byte), .evt_last(evt_last), .evt_ready(evt_ready), .conn_open(conn_open),
    .conn_close(conn_close), .conn_new_hdl(conn_new_hdl), .flush_evt(flush_evt), .ack_evt(ack_evt),
    .rssi_level(rssi_level), .country_sel(country_sel), .dev_addr(dev_addr));
  host_model host (.ref_clk(ref_clk), .sys_rst(sys_rst), .evt_valid(evt_valid), .evt_byte(evt_byte),
    .evt_last(evt_last), .evt_ready(evt_ready));

  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ======================================================================
  // reporting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ======================================================================
  // reference model
  function automatic int find(input logic [15:0] h);
    for (int s = 0; s < 8; s++)
      if (live[s] && hdl_of[s] === h)
        return s;
    return -1;
  endfunction

  function automatic void build(input logic [15:0] op, input logic [15:0] h);
    logic [7:0] st;
    logic [7:0] p[$];
    int s;
    st = 8'h00;
    p = {};
    s = find(h);
    case (op)
      16'h1005: p = {8'h00, 8'h01, 8'h40, 8'h08, 8'h00, 8'h04, 8'h00};
      16'h1007:
      begin
        // a reserved strap still fills the code byte, with zero
        p = {country_sel};
        if (country_sel > 8'h03)
        begin
          st = 8'h1F;
          p = {8'h00};
        end
      end
      16'h1009: for (int i = 0; i < 6; i++) p.push_back(dev_addr[8*i +: 8]);
      16'h1401, 16'h1402, 16'h1405:
      begin
        p = {h[7:0], h[15:8]};
        if (s < 0)
          st = 8'h02;
        else if (op[3:0] == 4'h1)
          p = {p, 8'(cnt[s]), 8'(cnt[s] >> 8)};
        else if (op[3:0] == 4'h2)
          cnt[s] = 0;
        else
          p.push_back(rssi_level[s]);
      end
      default: st = 8'h01;
    endcase
    exp_q = {8'h0E, 8'(p.size() + 4), 8'h01, op[7:0], op[15:8], st};
    exp_q = {exp_q, p};
  endfunction

  // ======================================================================
  // drivers
  task automatic cmd(input logic [15:0] op, input logic [15:0] h, input logic m);
    int n;
    host.got.delete();
    host.lasts = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_handle <= h;
    evt_mask <= m;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    build(op, h);
    if (m)
      exp_q = {};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      // counted and carried on, so the run still ends in the one report
      err_count++;
      $display("FAIL %0t command never finished", $time);
    end
    chk(host.got.size(), exp_q.size(), "event length");
    chk(host.lasts, m ? 0 : 1, "last marker");
    for (int i = 0; i < exp_q.size() && i < host.got.size(); i++)
      chk(host.got[i], exp_q[i], "event byte");
  endtask

  // counter pulses, model keeps the controller's open-flush-ack priority, but a close here also blocks flush and ack
  task automatic pulse(input logic [7:0] o, input logic [7:0] c, input logic [7:0] f, input logic [7:0] a,
    input logic [11:0] h);
    @(posedge ref_clk);
    conn_open <= o;
    conn_close <= c;
    flush_evt <= f;
    ack_evt <= a;
    conn_new_hdl <= h;
    for (int s = 0; s < 8; s++)
    begin
      if (o[s])
      begin
        live[s] = 1;
        hdl_of[s] = {4'h0, h};
        cnt[s] = 0;
      end
      else if (c[s])
        live[s] = 0;
      else if (f[s])
        cnt[s] = (cnt[s] == 65535) ? cnt[s] : cnt[s] + 1;
      else if (a[s])
        cnt[s] = 0;
    end
    @(posedge ref_clk);
    conn_open <= 8'h00;
    conn_close <= 8'h00;
    flush_evt <= 8'h00;
    ack_evt <= 8'h00;
  endtask

  // ======================================================================
  // main sequence
  initial
  begin
    dev_addr <= {$random(seed), $random(seed)};
    for (int s = 0; s < 8; s++)
      rssi_level[s] <= 8'($random(seed));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chk(cmd_ready, 1'b1, "ready after reset");
    chk(evt_valid, 1'b0, "no event after reset");
    cmd(16'h1005, 16'h0000, 1'b0);
    for (int c = 0; c < 6; c++)
    begin
      @(posedge ref_clk);
      country_sel <= (c == 5) ? 8'hFF : 8'(c);
      cmd(16'h1007, 16'h0000, 1'b0);
    end
    cmd(16'h1009, 16'h0000, 1'b0);
    cmd(16'h1005, 16'h0000, 1'b1);
    $display("test info queries done");
    for (int s = 0; s < 8; s++)
      pulse(8'(1 << s), 8'h00, 8'h00, 8'h00, 12'hEF8 + 12'(s));
    repeat (60)
      pulse(8'h00, 8'h00, 8'($random(seed)), 8'($random(seed)) & 8'($random(seed)), 12'h000);
    for (int s = 0; s < 8; s++)
      cmd(16'h1401, hdl_of[s], 1'b0);
    cmd(16'h1402, hdl_of[3], 1'b0);
    cmd(16'h1401, hdl_of[3], 1'b0);
    pulse(8'h00, 8'h00, 8'h08, 8'h00, 12'h000);
    pulse(8'h00, 8'h00, 8'h00, 8'h08, 12'h000);
    pulse(8'h00, 8'h00, 8'h04, 8'h00, 12'h000);
    pulse(8'h04, 8'h00, 8'h00, 8'h00, 12'h000);
    cmd(16'h1401, hdl_of[3], 1'b0);
    cmd(16'h1401, 16'h0EFA, 1'b0);
    cmd(16'h1401, 16'h0000, 1'b0);
    $display("test contact counters done");
    pulse(8'h00, 8'h20, 8'h00, 8'h00, 12'h000);
    cmd(16'h1401, 16'h0EFD, 1'b0);
    cmd(16'h1401, 16'h0F00, 1'b0);
    cmd(16'h1402, 16'h0FFF, 1'b0);
    cmd(16'h1403, hdl_of[0], 1'b0);
    cmd(16'h0000, 16'h0000, 1'b0);
    for (int s = 0; s < 8; s++)
      cmd(16'h1405, hdl_of[s], 1'b0);
    $display("test status errors done");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int s = 0; s < 8; s++)
    begin
      live[s] = 0;
      cnt[s] = 0;
    end
    #1;
    chk(cmd_ready, 1'b1, "ready after second reset");
    chk(evt_valid, 1'b0, "no event after second reset");
    cmd(16'h1405, hdl_of[2], 1'b0);
    pulse(8'h02, 8'h00, 8'h00, 8'h00, 12'h123);
    pulse(8'h00, 8'h00, 8'h02, 8'h00, 12'h000);
    cmd(16'h1401, 16'h0123, 1'b0);
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire

// ==== dv/host_model.sv ====
// host side that drains command-complete event bytes with random stalls
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic evt_valid,
  input wire logic [7:0] evt_byte,
  input wire logic evt_last,
  output logic evt_ready
);
  logic [7:0] got[$];
  int lasts;
  int seed;
  initial
  begin
    evt_ready = 1'b0;
    lasts = 0;
    seed = 32'hF087B75C;
  end
  // ======================================================================
  // byte intake
  // stalls are random so the held-byte path gets exercised
  always @(posedge ref_clk)
  begin
    if (!sys_rst && evt_valid && evt_ready)
    begin
      got.push_back(evt_byte);
      lasts = lasts + int'(evt_last);
    end
    evt_ready <= !sys_rst && ($random(seed) % 3 != 0);
  end
endmodule
`default_nettype wire

// ==== pkg/cnt_if.sv ====
// carrier between the command engine and the contact counter store
`timescale 1ns/100ps
`default_nettype none
interface cnt_if;
  logic [hci_pkg::NUM_CONN-1:0] inc;
  logic [hci_pkg::NUM_CONN-1:0] clr;
  logic [hci_pkg::NUM_CONN-1:0] ack;
  logic [hci_pkg::SLOT_W-1:0] rd_slot;
  logic [hci_pkg::CNT_W-1:0] rd_data;
  modport ctl (output inc, output clr, output ack, output rd_slot, input rd_data);
  modport mem (input inc, input clr, input ack, input rd_slot, output rd_data);
endinterface
`default_nettype wire

// ==== pkg/hci_pkg.sv ====
// constants, types and helpers for the informational and status command block
// ======================================================================
// Function
// - buffer-size answer ends with a two-byte total count of voice packets.
// - every finished command emits a command-complete event unless masked.
// - each answer carries a one-byte status, zero ok, nonzero an error code.
// - country query has no parameters and returns one band-selection byte.
// - country codes 0x00 to 0x03 defined, 0x04 and above reserved.
// - address query returns the 48-bit device address as six bytes.
// - status group commands are decoded under group field 0x05.
// - only the controller updates status values from its own state; here the host reset command also clears a counter.
// - each connection keeps a counter of consecutive flushed contacts.
// - each flush incident raises that connection's counter by one.
// - counter cleared on new connection and on a naming reset command.
// - a nonzero counter clears when a packet on it is acknowledged.
// - handle travels in two bytes, only the low 12 bits meaningful; here all 16 bits must be at most 0x0EFF for a match.
// - handles 0x0000 to 0x0EFF valid, 0x0F00 to 0x0FFF reserved.
// - status group returns received signal strength for a named handle.
// - counter read returns status, echoed handle, then two-byte counter.
package hci_pkg;
  localparam int unsigned NUM_CONN = 8;
  localparam int unsigned SLOT_W = 3;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned HDL_W = 12;
  localparam int unsigned PAY_MAX = 16;
  localparam int unsigned IDX_W = 4;

  localparam logic [5:0] OGF_INFO = 6'h04;
  localparam logic [5:0] OGF_STATUS = 6'h05;
  localparam logic [9:0] OCF_BUF = 10'h005;
  localparam logic [9:0] OCF_COUNTRY = 10'h007;
  localparam logic [9:0] OCF_ADDR = 10'h009;
  localparam logic [9:0] OCF_RD_FCC = 10'h001;
  localparam logic [9:0] OCF_RST_FCC = 10'h002;
  localparam logic [9:0] OCF_RSSI = 10'h005;

  localparam logic [7:0] EVT_CC = 8'h0E;
  localparam logic [7:0] NUM_CMD_PKTS = 8'h01;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_UNKNOWN = 8'h01;
  localparam logic [7:0] ST_NO_CONN = 8'h02;
  localparam logic [7:0] ST_UNSPEC = 8'h1F;
  localparam logic [7:0] CC_RESERVED = 8'h04;

  localparam logic [15:0] HDL_MAX = 16'h0EFF;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // buffer figures of this controller build
  localparam logic [15:0] ACL_LEN = 16'h0100;
  localparam logic [7:0] SCO_LEN = 8'h40;
  localparam logic [15:0] ACL_NUM = 16'h0008;
  localparam logic [15:0] SCO_NUM = 16'h0004;

  // byte positions inside the event
  localparam int P_CODE = 0;
  localparam int P_LEN = 1;
  localparam int P_NUM = 2;
  localparam int P_OPL = 3;
  localparam int P_OPH = 4;
  localparam int P_STAT = 5;
  localparam int P_P0 = 6;

  // total event bytes per answer
  localparam logic [IDX_W-1:0] LEN_HDR = 4'h2;
  localparam logic [IDX_W-1:0] LEN_BASE = 4'h6;
  localparam logic [IDX_W-1:0] LEN_BUF = 4'hD;
  localparam logic [IDX_W-1:0] LEN_CC = 4'h7;
  localparam logic [IDX_W-1:0] LEN_ADDR = 4'hC;
  localparam logic [IDX_W-1:0] LEN_HDL = 4'h8;
  localparam logic [IDX_W-1:0] LEN_FCC = 4'hA;
  localparam logic [IDX_W-1:0] LEN_RSSI = 4'h9;
  localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_LOOK = 4'b0010,
    S_SEND = 4'b0100,
    S_DRAIN = 4'b1000
  } cmd_state_t;

  function automatic logic is_op(input logic [15:0] op, input logic [5:0] ogf, input logic [9:0] ocf);
    return op == {ogf, ocf};
  endfunction

  function automatic logic handle_ok(input logic [15:0] h);
    return h <= HDL_MAX;
  endfunction
endpackage

// ==== src/contact_mem.sv ====
// per-connection failed-contact counters with registered read port
`timescale 1ns/100ps
`default_nettype none
module contact_mem (
  input wire logic ref_clk,
  input wire logic sys_rst,
  cnt_if.mem bus
);
  typedef struct packed {
    logic [hci_pkg::NUM_CONN-1:0][hci_pkg::CNT_W-1:0] cnt;
    logic [hci_pkg::CNT_W-1:0] rd;
  } mem_state_t;

  mem_state_t s;
  mem_state_t next_s;

  // ======================================================================
  // counter update
  always_comb
  begin
    next_s = s;
    next_s.rd = s.cnt[bus.rd_slot];
    for (int i = 0; i < hci_pkg::NUM_CONN; i++)
    begin
      if (bus.clr[i])
        next_s.cnt[i] = hci_pkg::CNT_ZERO;
      else if (bus.inc[i])
      begin
        // saturate rather than wrap to zero, which would fake a good link
        if (s.cnt[i] != hci_pkg::CNT_MAX)
          next_s.cnt[i] = s.cnt[i] + 16'h0001;
      end
      else if (bus.ack[i] && s.cnt[i] != hci_pkg::CNT_ZERO)
        next_s.cnt[i] = hci_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign bus.rd_data = s.rd;

  // ======================================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  for (genvar g = 0; g < hci_pkg::NUM_CONN; g++)
  begin : chk
    cnt_step_a: assert property (bus.inc[g] && !bus.clr[g] && s.cnt[g] != hci_pkg::CNT_MAX
      |=> s.cnt[g] == $past(s.cnt[g]) + 16'h0001)
      else $error("contact counter did not step by one");
    cnt_clear_a: assert property (bus.clr[g] |=> s.cnt[g] == hci_pkg::CNT_ZERO)
      else $error("contact counter not cleared");
    ack_clear_a: assert property (bus.ack[g] && !bus.inc[g] |=> s.cnt[g] == hci_pkg::CNT_ZERO)
      else $error("acknowledge did not clear counter");
  end
endmodule
`default_nettype wire

// ==== src/hci_info_status.sv ====
// command engine for informational and status-parameter queries
`timescale 1ns/100ps
`default_nettype none
module hci_info_status (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_opcode,
  input wire logic [15:0] cmd_handle,
  input wire logic evt_mask,
  output logic cmd_ready,
  output logic evt_valid,
  output logic [7:0] evt_byte,
  output logic evt_last,
  input wire logic evt_ready,
  input wire logic [hci_pkg::NUM_CONN-1:0] conn_open,
  input wire logic [hci_pkg::NUM_CONN-1:0] conn_close,
  input wire logic [hci_pkg::HDL_W-1:0] conn_new_hdl,
  input wire logic [hci_pkg::NUM_CONN-1:0] flush_evt,
  input wire logic [hci_pkg::NUM_CONN-1:0] ack_evt,
  input wire logic [hci_pkg::NUM_CONN-1:0][7:0] rssi_level,
  input wire logic [7:0] country_sel,
  input wire logic [47:0] dev_addr
);
  typedef struct packed {
    hci_pkg::cmd_state_t st;
    logic ready;
    logic ev_valid;
    logic [7:0] ev_byte;
    logic ev_last;
    logic [15:0] op;
    logic [15:0] hdl;
    logic hit;
    logic [hci_pkg::SLOT_W-1:0] slot;
    logic masked;
    logic [hci_pkg::PAY_MAX-1:0][7:0] pay;
    logic [hci_pkg::IDX_W-1:0] len;
    logic [hci_pkg::IDX_W-1:0] idx;
    logic [hci_pkg::NUM_CONN-1:0] conn_valid;
    logic [hci_pkg::NUM_CONN-1:0][hci_pkg::HDL_W-1:0] conn_hdl;
  } eng_state_t;

  eng_state_t s;
  eng_state_t next_s;
  cnt_if cnt_bus ();
  logic hit_c;
  logic [hci_pkg::SLOT_W-1:0] slot_c;
  logic accept;
  logic op_rd;
  logic op_rst;
  logic op_rssi;

  contact_mem u_mem (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .bus(cnt_bus.mem)
  );

  // ======================================================================
  // handle lookup and decode
  always_comb
  begin
    hit_c = 1'b0;
    slot_c = '0;
    // reserved handles never match, whatever the table holds
    if (hci_pkg::handle_ok(cmd_handle))
    begin
      for (int i = 0; i < hci_pkg::NUM_CONN; i++)
      begin
        if (!hit_c && s.conn_valid[i] && s.conn_hdl[i] == cmd_handle[hci_pkg::HDL_W-1:0])
        begin
          hit_c = 1'b1;
          slot_c = i[hci_pkg::SLOT_W-1:0];
        end
      end
    end
  end

  assign accept = s.ready && cmd_valid;
  assign op_rd = hci_pkg::is_op(s.op, hci_pkg::OGF_STATUS, hci_pkg::OCF_RD_FCC);
  assign op_rst = hci_pkg::is_op(s.op, hci_pkg::OGF_STATUS, hci_pkg::OCF_RST_FCC);
  assign op_rssi = hci_pkg::is_op(s.op, hci_pkg::OGF_STATUS, hci_pkg::OCF_RSSI);

  // counters move only on link events and the reset command
  assign cnt_bus.inc = flush_evt;
  assign cnt_bus.ack = ack_evt;
  assign cnt_bus.rd_slot = (s.st == hci_pkg::S_IDLE) ? slot_c : s.slot;

  always_comb
  begin
    cnt_bus.clr = conn_open;
    if (accept && hit_c && hci_pkg::is_op(cmd_opcode, hci_pkg::OGF_STATUS, hci_pkg::OCF_RST_FCC))
      cnt_bus.clr[slot_c] = 1'b1;
  end

  // ======================================================================
  // engine
  always_comb
  begin
    next_s = s;
    for (int i = 0; i < hci_pkg::NUM_CONN; i++)
    begin
      if (conn_close[i])
        next_s.conn_valid[i] = 1'b0;
      if (conn_open[i])
      begin
        next_s.conn_valid[i] = 1'b1;
        next_s.conn_hdl[i] = conn_new_hdl;
      end
    end
    unique case (s.st)
      hci_pkg::S_IDLE:
      begin
        if (accept)
        begin
          next_s.op = cmd_opcode;
          next_s.hdl = cmd_handle;
          next_s.hit = hit_c;
          next_s.slot = slot_c;
          next_s.masked = evt_mask;
          next_s.ready = 1'b0;
          next_s.st = hci_pkg::S_LOOK;
        end
      end
      hci_pkg::S_LOOK:
      begin
        next_s.pay = '0;
        next_s.pay[hci_pkg::P_CODE] = hci_pkg::EVT_CC;
        next_s.pay[hci_pkg::P_NUM] = hci_pkg::NUM_CMD_PKTS;
        next_s.pay[hci_pkg::P_OPL] = s.op[7:0];
        next_s.pay[hci_pkg::P_OPH] = s.op[15:8];
        next_s.pay[hci_pkg::P_STAT] = hci_pkg::ST_UNKNOWN;
        next_s.len = hci_pkg::LEN_BASE;
        if (hci_pkg::is_op(s.op, hci_pkg::OGF_INFO, hci_pkg::OCF_BUF))
        begin
          next_s.pay[hci_pkg::P_STAT] = hci_pkg::ST_OK;
          next_s.pay[hci_pkg::P_P0] = hci_pkg::ACL_LEN[7:0];
          next_s.pay[hci_pkg::P_P0+1] = hci_pkg::ACL_LEN[15:8];
          next_s.pay[hci_pkg::P_P0+2] = hci_pkg::SCO_LEN;
          next_s.pay[hci_pkg::P_P0+3] = hci_pkg::ACL_NUM[7:0];
          next_s.pay[hci_pkg::P_P0+4] = hci_pkg::ACL_NUM[15:8];
          next_s.pay[hci_pkg::P_P0+5] = hci_pkg::SCO_NUM[7:0];
          next_s.pay[hci_pkg::P_P0+6] = hci_pkg::SCO_NUM[15:8];
          next_s.len = hci_pkg::LEN_BUF;
        end
        else if (hci_pkg::is_op(s.op, hci_pkg::OGF_INFO, hci_pkg::OCF_COUNTRY))
        begin
          // a reserved strap is reported as a failure, never passed on
          if (country_sel < hci_pkg::CC_RESERVED)
          begin
            next_s.pay[hci_pkg::P_STAT] = hci_pkg::ST_OK;
            next_s.pay[hci_pkg::P_P0] = country_sel;
          end
          else
            next_s.pay[hci_pkg::P_STAT] = hci_pkg::ST_UNSPEC;
          next_s.len = hci_pkg::LEN_CC;
        end
        else if (hci_pkg::is_op(s.op, hci_pkg::OGF_INFO, hci_pkg::OCF_ADDR))
        begin
          next_s.pay[hci_pkg::P_STAT] = hci_pkg::ST_OK;
          for (int k = 0; k < 6; k++)
            next_s.pay[hci_pkg::P_P0+k] = dev_addr[8*k +: 8];
          next_s.len = hci_pkg::LEN_ADDR;
        end
        else if (op_rd || op_rst || op_rssi)
        begin
          next_s.pay[hci_pkg::P_P0] = s.hdl[7:0];
          next_s.pay[hci_pkg::P_P0+1] = s.hdl[15:8];
          next_s.len = hci_pkg::LEN_HDL;
          next_s.pay[hci_pkg::P_STAT] = s.hit ? hci_pkg::ST_OK : hci_pkg::ST_NO_CONN;
          if (s.hit && op_rd)
          begin
            next_s.pay[hci_pkg::P_P0+2] = cnt_bus.rd_data[7:0];
            next_s.pay[hci_pkg::P_P0+3] = cnt_bus.rd_data[15:8];
            next_s.len = hci_pkg::LEN_FCC;
          end
          if (s.hit && op_rssi)
          begin
            next_s.pay[hci_pkg::P_P0+2] = rssi_level[s.slot];
            next_s.len = hci_pkg::LEN_RSSI;
          end
        end
        next_s.pay[hci_pkg::P_LEN] = {4'h0, next_s.len - hci_pkg::LEN_HDR};
        next_s.idx = '0;
        if (s.masked)
        begin
          next_s.ready = 1'b1;
          next_s.st = hci_pkg::S_IDLE;
        end
        else
          next_s.st = hci_pkg::S_SEND;
      end
      hci_pkg::S_SEND:
      begin
        if (!s.ev_valid || evt_ready)
        begin
          next_s.ev_valid = 1'b1;
          next_s.ev_byte = s.pay[s.idx];
          next_s.ev_last = (s.idx == s.len - hci_pkg::IDX_ONE);
          next_s.idx = s.idx + hci_pkg::IDX_ONE;
          if (s.idx == s.len - hci_pkg::IDX_ONE)
            next_s.st = hci_pkg::S_DRAIN;
        end
      end
      hci_pkg::S_DRAIN:
      begin
        if (evt_ready)
        begin
          next_s.ev_valid = 1'b0;
          next_s.ev_last = 1'b0;
          next_s.ready = 1'b1;
          next_s.st = hci_pkg::S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.st <= hci_pkg::S_IDLE;
      s.ready <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign cmd_ready = s.ready;
  assign evt_valid = s.ev_valid;
  assign evt_byte = s.ev_byte;
  assign evt_last = s.ev_last;

  // ======================================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence take_s;
    s.ready && cmd_valid;
  endsequence

  sequence look_s;
    s.st == hci_pkg::S_LOOK;
  endsequence

  evt_code_a: assert property ($rose(evt_valid) |-> evt_byte == hci_pkg::EVT_CC)
    else $error("event does not open with completion code");
  evt_soon_a: assert property (take_s ##0 !evt_mask |-> ##[2:4] evt_valid)
    else $error("completion event missing");
  masked_quiet_a: assert property (take_s ##0 evt_mask |=> !evt_valid [*3])
    else $error("masked command still produced an event");
  ogf_check_a: assert property (look_s ##0 (s.op[15:10] != hci_pkg::OGF_STATUS && s.op[15:10] != hci_pkg::OGF_INFO)
    |=> s.pay[hci_pkg::P_STAT] == hci_pkg::ST_UNKNOWN)
    else $error("foreign group not refused");
  bad_handle_a: assert property (look_s ##0 (op_rd && !hci_pkg::handle_ok(s.hdl))
    |=> s.pay[hci_pkg::P_STAT] != hci_pkg::ST_OK && s.len == hci_pkg::LEN_HDL)
    else $error("reserved handle answered with data");
  fcc_data_a: assert property (look_s ##0 (op_rd && s.hit)
    |=> s.pay[hci_pkg::P_P0+2] == $past(cnt_bus.rd_data[7:0]) && s.len == hci_pkg::LEN_FCC)
    else $error("counter read returned wrong value");
  addr_byte_a: assert property (look_s ##0 hci_pkg::is_op(s.op, hci_pkg::OGF_INFO, hci_pkg::OCF_ADDR)
    |=> s.pay[hci_pkg::P_P0+5] == $past(dev_addr[47:40]) && s.pay[hci_pkg::P_STAT] == hci_pkg::ST_OK)
    else $error("device address not returned");
  country_rsv_a: assert property (look_s ##0 (hci_pkg::is_op(s.op, hci_pkg::OGF_INFO, hci_pkg::OCF_COUNTRY)
    && country_sel >= hci_pkg::CC_RESERVED) |=> s.pay[hci_pkg::P_STAT] != hci_pkg::ST_OK)
    else $error("reserved country code reported as success");
  country_ok_a: assert property (look_s ##0 (hci_pkg::is_op(s.op, hci_pkg::OGF_INFO, hci_pkg::OCF_COUNTRY)
    && country_sel < hci_pkg::CC_RESERVED) |=> s.pay[hci_pkg::P_P0] == $past(country_sel) && s.len == hci_pkg::LEN_CC)
    else $error("country code not returned");
  buf_tail_a: assert property (look_s ##0 hci_pkg::is_op(s.op, hci_pkg::OGF_INFO, hci_pkg::OCF_BUF)
    |=> s.pay[hci_pkg::P_P0+5] == hci_pkg::SCO_NUM[7:0] && s.pay[hci_pkg::P_P0+6] == hci_pkg::SCO_NUM[15:8])
    else $error("voice packet total not returned");
  rst_status_a: assert property (look_s ##0 (op_rst && s.hit)
    |=> s.pay[hci_pkg::P_STAT] == hci_pkg::ST_OK && s.len == hci_pkg::LEN_HDL)
    else $error("counter reset not confirmed");
  masked_back_a: assert property (take_s ##0 evt_mask |=> ##1 cmd_ready)
    else $error("masked command did not free the engine");
  busy_ready_a: assert property (take_s |=> !cmd_ready)
    else $error("engine still ready after taking a command");

  // ======================================================================
  // event framing checks
  // a stalled host must see the same byte, or it would skip one
  sequence stall_s;
    evt_valid && !evt_ready;
  endsequence

  sequence done_s;
    evt_valid && evt_ready && evt_last;
  endsequence

  evt_hold_a: assert property (stall_s |=> evt_valid && $stable(evt_byte) && $stable(evt_last))
    else $error("event byte changed while stalled");
  evt_end_a: assert property (done_s |=> !evt_valid && cmd_ready)
    else $error("event did not close after last byte");
  last_valid_a: assert property (evt_last |-> evt_valid)
    else $error("last marker without a valid byte");
endmodule
`default_nettype wire
